/* rtl/wdt_pkg.sv */
// Purpose: constants and types for the windowed watchdog timer
// Assumes: one clock (core_clk, 250 MHz), asynchronous active-low reset
// Notes: control and status bits are plain ports, no register bus
//
// What this block does
// RULE1: watchdog enabled after every reset
// RULE2: timeout select 0:0 disables the watchdog
// RULE3: write 0x55 then 0xAA restarts timeout
// RULE4: service writes leave status contents unchanged
// RULE5: missed service before overflow forces reset
// RULE6: any other written value resets immediately
// RULE7: clock select 0 is 1 kHz, 1 bus
// RULE8: 1 kHz counts 32, 256, 1024 cycles
// RULE9: bus counts 2^13, 2^16, 2^18 cycles
// RULE10: default is 1 kHz and longest timeout
// RULE11: window mode services only in last quarter
// RULE12: early service in window mode resets immediately
// RULE13: window enable ignored with 1 kHz clock
// RULE14: option registers lock after first write
// RULE15: bus clock: counter holds in stop, debug
// RULE16: 1 kHz clock: counter clears in stop, debug
// RULE17: software should write both option registers early
// RULE18: software should service from main flow
// RULE19: any reset clears counter, sequence, configuration
package wdt_pkg;

  localparam int CNT_W = 18;
  localparam logic [1:0] TSEL_OFF = 2'h0;
  localparam logic [1:0] TSEL_RESET = 2'h3;
  localparam logic CSEL_RESET = 1'h0;
  localparam logic WEN_RESET = 1'h0;

  localparam logic [15:0] SERVICE_FIRST = 16'h0055;
  localparam logic [15:0] SERVICE_SECOND = 16'h00AA;

  // overflow counts, 1 kHz source
  localparam logic [CNT_W-1:0] SLOW_LIMIT_1 = 18'h00020;
  localparam logic [CNT_W-1:0] SLOW_LIMIT_2 = 18'h00100;
  localparam logic [CNT_W-1:0] SLOW_LIMIT_3 = 18'h00400;
  // overflow counts, bus clock source
  localparam logic [CNT_W:0] BUS_LIMIT_1 = 19'h02000;
  localparam logic [CNT_W:0] BUS_LIMIT_2 = 19'h10000;
  localparam logic [CNT_W:0] BUS_LIMIT_3 = 19'h40000;
  // window opening points, bus clock source
  localparam logic [CNT_W-1:0] WIN_OPEN_1 = 18'h01800;
  localparam logic [CNT_W-1:0] WIN_OPEN_2 = 18'h0C000;
  localparam logic [CNT_W-1:0] WIN_OPEN_3 = 18'h30000;

  // 1 kHz tick divider from the 250 MHz core clock
  localparam int CORE_CLK_KHZ = 250000;
  localparam int SLOW_CLK_KHZ = 1;
  localparam int SLOW_DIV_CYCLES = CORE_CLK_KHZ / SLOW_CLK_KHZ;
  localparam int DIV_W = 18;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ARMED
  } wdt_seq_t;

endpackage

/* rtl/wdt_tick_gen.sv */
// Purpose: one-cycle tick at the slow watchdog clock rate
// Assumes: divide count of at least two
// Notes: restart pulse realigns the divider to a fresh period
module wdt_tick_gen #(
  parameter int DIVIDE = wdt_pkg::SLOW_DIV_CYCLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic restart,
  output logic tick
);
  import wdt_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] count;
    logic tick;
  } wdt_tick_state_t;

  localparam logic [DIV_W-1:0] LAST = DIV_W'(DIVIDE - 1);

  wdt_tick_state_t state_reg;
  wdt_tick_state_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (restart) begin
      state_next.count = '0;
    end else if (state_reg.count == LAST) begin
      state_next.count = '0;
      state_next.tick = 1'b1;
    end else begin
      state_next.count = state_reg.count + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick = state_reg.tick;
endmodule

/* rtl/wdt_core.sv */
// Purpose: windowed watchdog timer with write-once options and service sequence
// Assumes: cpu write strobes are one-cycle pulses synchronous to core_clk
// Notes: the reset request is a registered level held until system reset
module wdt_core #(
  parameter int SLOW_DIVIDE = wdt_pkg::SLOW_DIV_CYCLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic statusWrite,
  input wire logic [15:0] statusWriteData,
  input wire logic [7:0] resetStatusIn,
  output logic [7:0] reset_status_reg,
  input wire logic optOneWrite,
  input wire logic [1:0] optOneTimeoutSel,
  input wire logic optTwoWrite,
  input wire logic optTwoClockSel,
  input wire logic optTwoWindowEn,
  input wire logic stopMode,
  input wire logic debugMode,
  output logic [1:0] watchdog_timeout_sel,
  output logic watchdog_clock_sel,
  output logic watchdog_window_en,
  output logic [wdt_pkg::CNT_W-1:0] watchdogCount,
  output logic windowOpen,
  output logic watchdogReset
);
  import wdt_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] timeoutSel;
    logic clockSel;
    logic windowEn;
    logic optOneLocked;
    logic optTwoLocked;
    logic [CNT_W-1:0] count;
    wdt_seq_t seq;
    logic haltPrev;
    logic [7:0] status;
    logic resetReq;
  } wdt_state_t;

  wdt_state_t state_reg;
  wdt_state_t state_next;

  logic slowTick;
  logic halted;
  logic enabled;
  logic windowed;
  logic [CNT_W:0] limit;
  logic [CNT_W-1:0] openAt;
  logic overflow;
  logic isFirst;
  logic isSecond;

  assign halted = stopMode | debugMode;

  // ----------------------------------------------------------------
  // slow clock tick
  // ----------------------------------------------------------------
  wdt_tick_gen #(
    .DIVIDE(SLOW_DIVIDE)
  ) u_tick (
    .core_clk(core_clk),
    .resetn(resetn),
    .restart(halted),
    .tick(slowTick)
  );

  // ----------------------------------------------------------------
  // timeout decode
  // ----------------------------------------------------------------
  always_comb begin
    limit = BUS_LIMIT_3;
    openAt = WIN_OPEN_3;
    if (state_reg.clockSel) begin // see RULE7
      unique case (state_reg.timeoutSel)
        2'h1: begin
          limit = BUS_LIMIT_1; // see RULE9
          openAt = WIN_OPEN_1; // see RULE12
        end
        2'h2: begin
          limit = BUS_LIMIT_2; // see RULE9
          openAt = WIN_OPEN_2;
        end
        default: begin
          limit = BUS_LIMIT_3; // see RULE9
          openAt = WIN_OPEN_3;
        end
      endcase
    end else begin
      openAt = '0;
      unique case (state_reg.timeoutSel)
        2'h1: limit = {1'b0, SLOW_LIMIT_1}; // see RULE8
        2'h2: limit = {1'b0, SLOW_LIMIT_2}; // see RULE8
        default: limit = {1'b0, SLOW_LIMIT_3}; // see RULE8
      endcase
    end
  end

  assign enabled = state_reg.timeoutSel != TSEL_OFF; // see RULE2
  assign windowed = state_reg.windowEn & state_reg.clockSel; // see RULE11 see RULE13
  assign overflow = ({1'b0, state_reg.count} + 19'h00001) >= limit;
  assign isFirst = statusWriteData == SERVICE_FIRST;
  assign isSecond = statusWriteData == SERVICE_SECOND;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.haltPrev = halted;
    state_next.status = resetStatusIn; // see RULE4

    // write-once options
    if (optOneWrite && !state_reg.optOneLocked) begin
      state_next.timeoutSel = optOneTimeoutSel; // see RULE14
      state_next.optOneLocked = 1'b1;
    end
    if (optTwoWrite && !state_reg.optTwoLocked) begin
      state_next.clockSel = optTwoClockSel; // see RULE14
      state_next.windowEn = optTwoWindowEn;
      state_next.optTwoLocked = 1'b1;
    end

    // counter
    if (!state_reg.clockSel) begin
      if (halted && !state_reg.haltPrev) begin
        state_next.count = '0; // see RULE16
      end else if (!halted && slowTick && enabled) begin
        state_next.count = state_reg.count + 1'b1;
      end
    end else if (!halted && enabled) begin // see RULE15
      state_next.count = state_reg.count + 1'b1;
    end

    if (enabled && !halted && overflow &&
        (state_reg.clockSel || slowTick)) begin
      state_next.resetReq = 1'b1; // see RULE5
    end

    // service sequence
    if (statusWrite) begin
      if (!isFirst && !isSecond) begin
        state_next.resetReq = 1'b1; // see RULE6
      end else if (enabled && windowed && state_reg.count < openAt) begin
        state_next.resetReq = 1'b1; // see RULE12
      end else if (isFirst) begin
        state_next.seq = SEQ_ARMED;
      end else if (state_reg.seq == SEQ_ARMED) begin
        state_next.seq = SEQ_IDLE;
        state_next.count = '0; // see RULE3
      end else begin
        state_next.seq = SEQ_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg.timeoutSel <= TSEL_RESET; // see RULE1 see RULE10 see RULE19
      state_reg.clockSel <= CSEL_RESET; // see RULE10
      state_reg.windowEn <= WEN_RESET;
      state_reg.optOneLocked <= 1'b0;
      state_reg.optTwoLocked <= 1'b0;
      state_reg.count <= '0; // see RULE19
      state_reg.seq <= SEQ_IDLE;
      state_reg.haltPrev <= 1'b0;
      state_reg.status <= 8'h00;
      state_reg.resetReq <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reset_status_reg = state_reg.status;
  assign watchdog_timeout_sel = state_reg.timeoutSel;
  assign watchdog_clock_sel = state_reg.clockSel;
  assign watchdog_window_en = state_reg.windowEn;
  assign watchdogCount = state_reg.count;
  assign windowOpen = !windowed || (state_reg.count >= openAt);
  assign watchdogReset = state_reg.resetReq;
endmodule

/* test/wdt_core_properties.sv */
// Purpose: concurrent checks on wdt_core ports
// Assumes: bound to every wdt_core instance
// Notes: armed flag tracks the first service value
module wdt_core_properties (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic statusWrite,
  input wire logic [15:0] statusWriteData,
  input wire logic [7:0] resetStatusIn,
  input wire logic [7:0] reset_status_reg,
  input wire logic stopMode,
  input wire logic debugMode,
  input wire logic [1:0] watchdog_timeout_sel,
  input wire logic watchdog_clock_sel,
  input wire logic watchdog_window_en,
  input wire logic [wdt_pkg::CNT_W-1:0] watchdogCount,
  input wire logic windowOpen,
  input wire logic watchdogReset
);
  import wdt_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic armed_reg;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) armed_reg <= 1'b0;
    else if (statusWrite) armed_reg <= statusWriteData == SERVICE_FIRST;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ----
  // checks
  // ----
  bad_value_a: assert property (
    statusWrite && statusWriteData != SERVICE_FIRST && statusWriteData != SERVICE_SECOND
    |=> watchdogReset) else $error("bad value without reset");
  svc_clear_a: assert property (
    statusWrite && statusWriteData == SERVICE_SECOND && armed_reg && windowOpen
    && watchdog_timeout_sel != TSEL_OFF && !watchdogReset |=> watchdogCount == '0)
    else $error("service did not clear count");
  reset_sticky_a: assert property (watchdogReset |=> watchdogReset)
    else $error("reset request dropped");
  status_copy_a: assert property (1'b1 |=> reset_status_reg == $past(resetStatusIn))
    else $error("status not a copy");
  off_hold_a: assert property (
    watchdog_timeout_sel == TSEL_OFF && !statusWrite && !stopMode && !debugMode
    |=> $stable(watchdogCount) && $stable(watchdogReset)) else $error("disabled but active");
  bus_hold_a: assert property (
    watchdog_clock_sel && (stopMode || debugMode) && !statusWrite |=> $stable(watchdogCount))
    else $error("count moved while halted");
  slow_clear_a: assert property (
    !watchdog_clock_sel && $rose(stopMode || debugMode) |=> watchdogCount == '0)
    else $error("slow count not cleared");
  win_early_a: assert property (
    watchdog_clock_sel && watchdog_window_en && watchdog_timeout_sel == 2'h1
    && watchdogCount < WIN_OPEN_1 && statusWrite |=> watchdogReset)
    else $error("early service accepted");
  cover property ($rose(watchdogReset));
  cover property (statusWrite && windowOpen && watchdog_window_en);
  cover property (watchdog_clock_sel && stopMode);
endmodule
bind wdt_core wdt_core_properties chk (.*);

/* test/tb_windowed_watchdog_timer.sv */
// Purpose: self-checking bench for wdt_core
// Assumes: slow divider shortened to 8 core cycles
// Notes: bench pulls resetn low after each watchdog reset
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb_windowed_watchdog_timer;
  timeunit 1ns;
  timeprecision 100ps;
  import wdt_pkg::*;
  localparam int DIV = 8;
  logic core_clk = 0, resetn = 0, statusWrite = 0, optOneWrite = 0, optTwoWrite = 0;
  logic optTwoClockSel = 0, optTwoWindowEn = 0, stopMode = 0, debugMode = 0;
  logic watchdog_clock_sel, watchdog_window_en, windowOpen, watchdogReset;
  logic [15:0] statusWriteData = '0;
  logic [7:0] resetStatusIn = '0, reset_status_reg;
  logic [1:0] optOneTimeoutSel = '0, watchdog_timeout_sel;
  logic [CNT_W-1:0] watchdogCount, held;
  logic [15:0] bad[4] = '{16'h0155, 16'hAA00, 16'h0000, 16'h1234};
  logic [31:0] seed = 32'h000119E2;
  int fail_count = 0, num_checks = 0, n;
  wdt_core #(.SLOW_DIVIDE(DIV)) uut (.*);
  initial forever #2 core_clk = ~core_clk;
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic sysrst();
    @(posedge core_clk);
    resetn <= 1'b0;
    resetStatusIn <= 8'(rnd());
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    #1;
    `CHK("tsel", TSEL_RESET, watchdog_timeout_sel)
    `CHK("csel", CSEL_RESET, watchdog_clock_sel)
    `CHK("wen", WEN_RESET, watchdog_window_en)
    `CHK("cnt", '0, watchdogCount)
  endtask
  task automatic wr(input logic [15:0] d);
    @(posedge core_clk);
    statusWrite <= 1'b1;
    statusWriteData <= d;
    @(posedge core_clk);
    statusWrite <= 1'b0;
    #1;
  endtask
  // both option registers written together at init
  task automatic cfg(input logic [1:0] t, input logic c, input logic w);
    @(posedge core_clk);
    {optOneWrite, optTwoWrite, optOneTimeoutSel, optTwoClockSel, optTwoWindowEn} <= {2'h3, t, c, w};
    @(posedge core_clk);
    {optOneWrite, optTwoWrite} <= 2'h0;
    #1;
  endtask
  // serviced from the main scenario flow only
  task automatic svc();
    wr(SERVICE_FIRST);
    wr(SERVICE_SECOND);
    `CHK("svc", '0, watchdogCount)
  endtask
  task automatic wt(input int lim, input bit w);
    n = 0;
    while ((w ? windowOpen : watchdogReset) !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      finish_test();
    end
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    bad[3] = rnd() | 16'h0100;
    sysrst();
    cfg(2'h1, 1'b0, 1'b1);
    cfg(2'h0, 1'b1, 1'b0);
    `CHK("lock", 2'h1, watchdog_timeout_sel)
    `CHK("lockc", 1'b0, watchdog_clock_sel)
    `CHK("lockw", 1'b1, watchdog_window_en)
    `CHK("slowwin", 1'b1, windowOpen)
    svc();
    `CHK("early", 1'b0, watchdogReset)
    repeat (40) @(posedge core_clk);
    debugMode <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK("dbg", '0, watchdogCount)
    @(posedge core_clk);
    debugMode <= 1'b0;
    svc();
    wt(400, 0);
    `CHK("slow", 1'b1, n > 31 * DIV && n <= 32 * DIV)
    sysrst();
    cfg(2'h1, 1'b1, 1'b0);
    svc();
    @(posedge core_clk);
    stopMode <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    held = watchdogCount;
    repeat (20) @(posedge core_clk);
    stopMode <= 1'b0;
    #1;
    `CHK("hold", held, watchdogCount)
    wt(9000, 0);
    `CHK("ovf", int'(BUS_LIMIT_1) - int'(held), n)
    sysrst();
    cfg(2'h1, 1'b1, 1'b1);
    `CHK("shut", 1'b0, windowOpen)
    wr(SERVICE_FIRST);
    `CHK("prem", 1'b1, watchdogReset)
    sysrst();
    cfg(2'h1, 1'b1, 1'b1);
    wt(8192, 1);
    `CHK("open", WIN_OPEN_1, watchdogCount)
    svc();
    `CHK("late", 1'b0, watchdogReset)
    sysrst();
    cfg(2'h0, 1'b1, 1'b0);
    repeat (9000) @(posedge core_clk);
    #1;
    `CHK("off", 1'b0, watchdogReset)
    foreach (bad[i]) begin
      wr(bad[i]);
      `CHK("bad", 1'b1, watchdogReset)
      `CHK("stat", resetStatusIn, reset_status_reg)
      sysrst();
    end
    finish_test();
  end
endmodule
